//--- verilog/tlviu_core.sv
// Two-level vectored interrupt unit: sampling, priority, blocking and register file
// Operation
// RL1: Each serial-port request is receive flag OR transmit flag.
// RL2: Serial flags are never cleared by vectoring; software clears them.
// RL3: Both serial ports alike; second port controls at aux bit 4.
// RL4: Each source has one level bit; 0 low, 1 high.
// RL5: High preempts low; nothing preempts high.
// RL6: High-level request served before low-level request in same poll.
// RL7: Equal-level ties broken by fixed polling order ext0 first, timer2 last.
// RL8: Per-source enable; global enable bit 7 low blocks all acknowledgment.
// RL9: Main enable map: 5 timer2, 4 uart1, 3 timer1, 2 ext1, 1 timer0, 0 ext0.
// RL10: Aux enable: bit 4 uart2, bit 1 two-wire; others unused.
// RL11: Main level map mirrors main enable map; bits 7 and 6 reserved.
// RL12: Aux level: bit 4 uart2, bit 1 two-wire; others unused.
// RL13: Flags sampled at the sample phase each machine cycle, polled next cycle.
// RL14: Call withheld while equal or higher level routine in progress.
// RL15: Call withheld unless current cycle is instruction's last.
// RL16: Call withheld during return-from-handler or control register access.
// RL17: Blocked requests are not remembered; each poll uses fresh samples.
// RL18: Acknowledge pushes program counter, not status word, then loads vector.
// RL19: Return-from-handler clears in-progress level and pops program counter.
// RL20: Plain return leaves in-progress state set.
// RL21: Vectors 0003,004B,000B,0043,0013,001B,0023,002B by source.
// RL22: External flag auto-cleared on vectoring only in edge mode.
// RL23: Timer0 and timer1 flags auto-cleared on service; timer2 not.
// RL24: Reserved and unused register bits read zero; writes ignored.
`timescale 1ns/1ns
module tlviu_core
    import tlviu_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Machine-cycle phase strobe
    input wire logic flag_sample_phase_i,
    // Register bus
    input wire tlviu_sfr_req_t sfr_req_i,
    output logic [7:0] sfr_rdata_o,
    // Sequencer status and flags
    input wire tlviu_instr_t instr_i,
    input wire tlviu_flags_t flags_i,
    // Call order, flag clears and in-progress levels
    output tlviu_call_t call_o,
    output logic ext0_clear_o,
    output logic ext1_clear_o,
    output logic timer0_clear_o,
    output logic timer1_clear_o,
    output logic [1:0] in_progress_o
);
    logic [7:0] enable_reg_main;
    logic [7:0] enable_reg_aux;
    logic [7:0] level_reg_main;
    logic [7:0] level_reg_aux;
    logic [NUM_SRC-1:0] sample_reg;
    logic [NUM_SRC-1:0] raw_req;
    logic [NUM_SRC-1:0] src_enable;
    logic [NUM_SRC-1:0] src_level;
    logic [NUM_SRC-1:0] live_req;
    logic [1:0] in_progress_reg;
    logic [1:0] in_progress_next;
    logic pick_valid;
    logic pick_high;
    logic [3:0] pick_idx;
    logic blocked;

    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        case (idx)
            4'd0: vector_of = VEC_EXT0;
            4'd1: vector_of = VEC_UART2;
            4'd2: vector_of = VEC_TIMER0;
            4'd3: vector_of = VEC_TWOWIRE;
            4'd4: vector_of = VEC_EXT1;
            4'd6: vector_of = VEC_TIMER1;
            4'd8: vector_of = VEC_UART1;
            4'd9: vector_of = VEC_TIMER2;
            default: vector_of = VEC_NONE;
        endcase
    endfunction // RL21

    // Raw requests in polling order
    always_comb begin
        raw_req = '0;
        raw_req[SRC_EXT0] = flags_i.ext0_flag;
        raw_req[SRC_UART2] = flags_i.uart2_recv_done_flag | flags_i.uart2_xmit_done_flag; // RL1 RL3
        raw_req[SRC_TIMER0] = flags_i.timer0_flag;
        raw_req[SRC_TWOWIRE] = flags_i.twowire_flag;
        raw_req[SRC_EXT1] = flags_i.ext1_flag;
        raw_req[SRC_TIMER1] = flags_i.timer1_flag;
        raw_req[SRC_UART1] = flags_i.uart1_recv_done_flag | flags_i.uart1_xmit_done_flag; // RL1
        raw_req[SRC_TIMER2] = flags_i.timer2_flag | flags_i.timer2_external_flag;
    end

    // Per-source enable and level bits
    always_comb begin
        src_enable = '0;
        src_level = '0;
        src_enable[SRC_EXT0] = enable_reg_main[0]; // RL9
        src_enable[SRC_TIMER0] = enable_reg_main[1];
        src_enable[SRC_EXT1] = enable_reg_main[2];
        src_enable[SRC_TIMER1] = enable_reg_main[3];
        src_enable[SRC_UART1] = enable_reg_main[4];
        src_enable[SRC_TIMER2] = enable_reg_main[5];
        src_enable[SRC_UART2] = enable_reg_aux[UART2_AUX_BIT]; // RL10 RL3
        src_enable[SRC_TWOWIRE] = enable_reg_aux[TWOWIRE_AUX_BIT];
        src_level[SRC_EXT0] = level_reg_main[0]; // RL11 RL4
        src_level[SRC_TIMER0] = level_reg_main[1];
        src_level[SRC_EXT1] = level_reg_main[2];
        src_level[SRC_TIMER1] = level_reg_main[3];
        src_level[SRC_UART1] = level_reg_main[4];
        src_level[SRC_TIMER2] = level_reg_main[5];
        src_level[SRC_UART2] = level_reg_aux[UART2_AUX_BIT]; // RL12
        src_level[SRC_TWOWIRE] = level_reg_aux[TWOWIRE_AUX_BIT];
    end

    // Sample gated flags once per machine cycle; no history kept
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sample_reg <= '0;
        end else if (flag_sample_phase_i) begin
            sample_reg <= raw_req & src_enable; // RL13 RL17
        end
    end

    assign live_req = enable_reg_main[GLOBAL_ENABLE_BIT] ? sample_reg : '0; // RL8

    // High level first, then lowest polling index
    always_comb begin
        pick_valid = 1'b0;
        pick_high = 1'b0;
        pick_idx = 4'd0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (live_req[i] && !src_level[i] && !pick_high) begin
                pick_valid = 1'b1;
                pick_idx = 4'(i);
            end
        end // RL7
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (live_req[i] && src_level[i]) begin
                pick_valid = 1'b1;
                pick_high = 1'b1;
                pick_idx = 4'(i);
            end
        end // RL6
    end

    // Blocking by running level and instruction state
    always_comb begin
        blocked = in_progress_reg[1] || (in_progress_reg[0] && !pick_high); // RL5 RL14
        blocked = blocked || !instr_i.last_cycle; // RL15
        blocked = blocked || instr_i.is_return_from_handler || instr_i.touches_ctrl; // RL16
    end

    // In-progress levels: set on call, top level dropped on return-from-handler
    always_comb begin
        in_progress_next = in_progress_reg;
        if (instr_i.is_return_from_handler && instr_i.last_cycle) begin
            if (in_progress_reg[1]) begin
                in_progress_next[1] = 1'b0;
            end else begin
                in_progress_next[0] = 1'b0;
            end // RL19
        end else if (pick_valid && !blocked) begin
            in_progress_next[pick_high] = 1'b1;
        end // RL20 plain return ignored
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_progress_reg <= 2'b00;
        end else begin
            in_progress_reg <= in_progress_next;
        end
    end
    assign in_progress_o = in_progress_reg;

    // Call order and flag clears registered toward the sequencer
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            call_o <= '0;
            ext0_clear_o <= 1'b0;
            ext1_clear_o <= 1'b0;
            timer0_clear_o <= 1'b0;
            timer1_clear_o <= 1'b0;
        end else begin
            call_o.call <= pick_valid && !blocked;
            call_o.push_pc <= pick_valid && !blocked; // RL18
            call_o.save_status <= 1'b0; // RL18
            call_o.vector <= (pick_valid && !blocked) ? vector_of(pick_idx) : VEC_NONE;
            call_o.pop_pc <= instr_i.last_cycle && (instr_i.is_return_from_handler || instr_i.is_ret); // RL19 RL20
            ext0_clear_o <= pick_valid && !blocked && pick_idx == 4'(SRC_EXT0) && flags_i.ext0_edge_mode; // RL22
            ext1_clear_o <= pick_valid && !blocked && pick_idx == 4'(SRC_EXT1) && flags_i.ext1_edge_mode; // RL22
            timer0_clear_o <= pick_valid && !blocked && pick_idx == 4'(SRC_TIMER0); // RL23
            timer1_clear_o <= pick_valid && !blocked && pick_idx == 4'(SRC_TIMER1); // RL23
        end // RL2 no serial or timer2 clear exists
    end

    // Register writes; masks keep unused bits at zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable_reg_main <= RST_ENABLE_MAIN;
            enable_reg_aux <= RST_ENABLE_AUX;
            level_reg_main <= RST_LEVEL_MAIN;
            level_reg_aux <= RST_LEVEL_AUX;
        end else if (sfr_req_i.wr) begin
            if (sfr_req_i.addr == ADDR_ENABLE_MAIN) begin
                enable_reg_main <= sfr_req_i.wdata & MASK_ENABLE_MAIN; // RL24
            end else if (sfr_req_i.addr == ADDR_ENABLE_AUX) begin
                enable_reg_aux <= sfr_req_i.wdata & MASK_AUX;
            end else if (sfr_req_i.addr == ADDR_LEVEL_MAIN) begin
                level_reg_main <= sfr_req_i.wdata & MASK_LEVEL_MAIN;
            end else if (sfr_req_i.addr == ADDR_LEVEL_AUX) begin
                level_reg_aux <= sfr_req_i.wdata & MASK_AUX;
            end
        end
    end

    // Read data registered; other addresses read zero
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sfr_rdata_o <= 8'h00_00;
        end else if (sfr_req_i.rd && sfr_req_i.addr == ADDR_ENABLE_MAIN) begin
            sfr_rdata_o <= enable_reg_main;
        end else if (sfr_req_i.rd && sfr_req_i.addr == ADDR_ENABLE_AUX) begin
            sfr_rdata_o <= enable_reg_aux;
        end else if (sfr_req_i.rd && sfr_req_i.addr == ADDR_LEVEL_MAIN) begin
            sfr_rdata_o <= level_reg_main;
        end else if (sfr_req_i.rd && sfr_req_i.addr == ADDR_LEVEL_AUX) begin
            sfr_rdata_o <= level_reg_aux;
        end else begin
            sfr_rdata_o <= 8'h00_00;
        end
    end

    // Checks
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);

    call_needs_last_a: assert property (call_o.call |-> $past(instr_i.last_cycle)) else $error("call off last cycle"); // RL15
    call_no_return_from_handler_a: assert property (call_o.call |-> !$past(instr_i.is_return_from_handler) && !$past(instr_i.touches_ctrl))
        else $error("call during blocked instr"); // RL16
    call_global_a: assert property (call_o.call |-> $past(enable_reg_main[7])) else $error("call while globally off"); // RL8
    high_no_preempt_a: assert property (call_o.call |-> !$past(in_progress_reg[1])) else $error("high preempted"); // RL5
    no_status_save_a: assert property (call_o.call |-> !call_o.save_status && call_o.push_pc) else $error("status saved"); // RL18
    return_from_handler_clears_a: assert property (instr_i.is_return_from_handler && instr_i.last_cycle && in_progress_reg == 2'b01
        |=> in_progress_reg == 2'b00) else $error("return did not clear"); // RL19
    ret_keeps_a: assert property (instr_i.is_ret && !instr_i.is_return_from_handler && in_progress_reg[1] |=> in_progress_reg[1])
        else $error("plain return cleared level"); // RL20
    vector_known_a: assert property (call_o.call |-> call_o.vector != VEC_NONE) else $error("bad vector"); // RL21
    reserved_zero_a: assert property ((enable_reg_main[6] == 1'b0) && (level_reg_main[7:6] == 2'b00)
        && ((enable_reg_aux & ~MASK_AUX) == 8'h00_00)) else $error("reserved bit set"); // RL24
    timer1_clear_a: assert property (timer1_clear_o |-> call_o.call && call_o.vector == VEC_TIMER1)
        else $error("timer1 clear mismatch"); // RL23

    // Masks for the polling-order check: requests of the chosen level that sit ahead of the pick
    logic [NUM_SRC-1:0] below_pick;
    logic [NUM_SRC-1:0] same_level;
    assign below_pick = (NUM_SRC'(1) << pick_idx) - NUM_SRC'(1);
    assign same_level = pick_high ? src_level : ~src_level;

    // Level choice and polling order
    high_first_a: assert property (pick_valid && (live_req & src_level) != '0 |-> pick_high) // RL6
        else $error("low before high");
    poll_order_a: assert property (pick_valid |-> (live_req & same_level & below_pick) == '0) // RL7
        else $error("tie order broken");
    pick_live_a: assert property (pick_valid |-> live_req[pick_idx]) // RL7
        else $error("pick without request");
    pick_any_a: assert property (live_req != '0 |-> pick_valid) // RL6
        else $error("request not picked");
    rsv_idle_a: assert property (!sample_reg[SRC_RSV5] && !sample_reg[SRC_RSV7]) // RL7
        else $error("reserved source active");

    // Sampling and gating
    sample_hold_a: assert property (!flag_sample_phase_i |=> $stable(sample_reg)) // RL13
        else $error("sample moved off phase");
    sample_fresh_a: assert property (flag_sample_phase_i |=> sample_reg == $past(raw_req & src_enable)) // RL17
        else $error("sample not fresh");
    global_off_a: assert property (!enable_reg_main[GLOBAL_ENABLE_BIT] |-> live_req == '0) // RL8
        else $error("request live while off");

    // Blocking and in-progress levels
    low_blocked_a: assert property (in_progress_reg[0] && !pick_high |=> !call_o.call) // RL14
        else $error("low over low");
    high_blocks_a: assert property (in_progress_reg[1] |=> !call_o.call) // RL5
        else $error("call over high");
    ctrl_blocks_a: assert property (instr_i.touches_ctrl |=> !call_o.call) // RL16
        else $error("call after control access");
    call_sets_a: assert property (call_o.call |-> in_progress_reg != 2'b00) // RL14
        else $error("call left no level");
    preempt_mark_a: assert property (pick_valid && pick_high && !blocked |=> in_progress_reg[1]) // RL5
        else $error("high level not marked");
    return_from_handler_high_a: assert property (instr_i.is_return_from_handler && instr_i.last_cycle && in_progress_reg[1] // RL19
        |=> !in_progress_reg[1])
        else $error("high level kept");
    ret_keeps_low_a: assert property (instr_i.is_ret && !instr_i.is_return_from_handler && in_progress_reg[0] // RL20
        |=> in_progress_reg[0])
        else $error("plain return cleared low");

    // Returns
    pop_on_return_a: assert property (instr_i.last_cycle && instr_i.is_ret |=> call_o.pop_pc) // RL19
        else $error("return did not pop");
    pop_cause_a: assert property (call_o.pop_pc |-> $past(instr_i.is_return_from_handler || instr_i.is_ret)) // RL19
        else $error("pop without return");

    // Flag clears go with the call that serves the source
    ext0_edge_a: assert property (ext0_clear_o |-> call_o.vector == VEC_EXT0 // RL22
        && $past(flags_i.ext0_edge_mode))
        else $error("ext0 clear wrong");
    ext0_level_a: assert property (call_o.call && call_o.vector == VEC_EXT0 // RL22
        |-> ext0_clear_o == $past(flags_i.ext0_edge_mode))
        else $error("ext0 clear missing");
    ext1_edge_a: assert property (ext1_clear_o |-> call_o.vector == VEC_EXT1 // RL22
        && $past(flags_i.ext1_edge_mode))
        else $error("ext1 clear wrong");
    ext1_level_a: assert property (call_o.call && call_o.vector == VEC_EXT1 // RL22
        |-> ext1_clear_o == $past(flags_i.ext1_edge_mode))
        else $error("ext1 clear missing");
    timer0_call_a: assert property (call_o.call && call_o.vector == VEC_TIMER0 |-> timer0_clear_o) // RL23
        else $error("timer0 clear missing");
    timer0_only_a: assert property (timer0_clear_o |-> call_o.vector == VEC_TIMER0) // RL23
        else $error("timer0 clear wrong");
    timer1_call_a: assert property (call_o.call && call_o.vector == VEC_TIMER1 |-> timer1_clear_o) // RL23
        else $error("timer1 clear missing");
    soft_clear_a: assert property (call_o.vector == VEC_UART1 || call_o.vector == VEC_UART2 // RL2
        || call_o.vector == VEC_TIMER2 |-> !timer0_clear_o && !timer1_clear_o && !ext0_clear_o)
        else $error("soft flag cleared");

    // Call shape and register reads
    idle_vector_a: assert property (!call_o.call |-> call_o.vector == VEC_NONE && !call_o.push_pc) // RL21
        else $error("idle vector set");
    status_never_a: assert property (!call_o.save_status) // RL18
        else $error("status save raised");
    rd_idle_zero_a: assert property (!sfr_req_i.rd |=> sfr_rdata_o == 8'h00_00) // RL24
        else $error("read data lingers");
    aux_level_zero_a: assert property ((level_reg_aux & ~MASK_AUX) == 8'h00_00) // RL24
        else $error("aux level bit set");
    rd_main_a: assert property (sfr_req_i.rd && sfr_req_i.addr == ADDR_ENABLE_MAIN // RL9
        |=> sfr_rdata_o == $past(enable_reg_main))
        else $error("main enable read wrong");

    call_seen_c: cover property (call_o.call);
    preempt_c: cover property (call_o.call && $past(in_progress_reg) == 2'b01);
    tie_c: cover property (pick_valid && $countones(live_req) > 1);
    nested_c: cover property (in_progress_reg == 2'b11);
    return_from_handler_c: cover property (instr_i.is_return_from_handler && in_progress_reg != 2'b00);
endmodule // tlviu_core

//--- verilog/tlviu_pkg.sv
// Package with register map, vectors and carrier types for the vectored interrupt unit
package tlviu_pkg;
    // Register addresses on the special-function bus
    localparam logic [7:0] ADDR_ENABLE_AUX = 8'h00_A7;
    localparam logic [7:0] ADDR_ENABLE_MAIN = 8'h00_A8;
    localparam logic [7:0] ADDR_LEVEL_AUX = 8'h00_B7;
    localparam logic [7:0] ADDR_LEVEL_MAIN = 8'h00_B8;
    // Reset values
    localparam logic [7:0] RST_ENABLE_AUX = 8'h00_00;
    localparam logic [7:0] RST_ENABLE_MAIN = 8'h00_00;
    localparam logic [7:0] RST_LEVEL_AUX = 8'h00_00;
    localparam logic [7:0] RST_LEVEL_MAIN = 8'h00_00;
    // Writable bit masks
    localparam logic [7:0] MASK_ENABLE_MAIN = 8'h00_BF;
    localparam logic [7:0] MASK_LEVEL_MAIN = 8'h00_3F;
    localparam logic [7:0] MASK_AUX = 8'h00_12;
    // Field positions
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int UART2_AUX_BIT = 4;
    localparam int TWOWIRE_AUX_BIT = 1;
    // Source indices in polling order, 0 is served first
    localparam int NUM_SRC = 10;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_UART2 = 1;
    localparam int SRC_TIMER0 = 2;
    localparam int SRC_TWOWIRE = 3;
    localparam int SRC_EXT1 = 4;
    localparam int SRC_RSV5 = 5;
    localparam int SRC_TIMER1 = 6;
    localparam int SRC_RSV7 = 7;
    localparam int SRC_UART1 = 8;
    localparam int SRC_TIMER2 = 9;
    // Vector addresses by polling index
    localparam logic [15:0] VEC_EXT0 = 16'h0003;
    localparam logic [15:0] VEC_UART2 = 16'h004B;
    localparam logic [15:0] VEC_TIMER0 = 16'h000B;
    localparam logic [15:0] VEC_TWOWIRE = 16'h0043;
    localparam logic [15:0] VEC_EXT1 = 16'h0013;
    localparam logic [15:0] VEC_TIMER1 = 16'h001B;
    localparam logic [15:0] VEC_UART1 = 16'h0023;
    localparam logic [15:0] VEC_TIMER2 = 16'h002B;
    localparam logic [15:0] VEC_NONE = 16'h0000;

    // Register access from the core
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tlviu_sfr_req_t;

    // Instruction status from the sequencer
    typedef struct packed {
        logic last_cycle;
        logic is_return_from_handler;
        logic is_ret;
        logic touches_ctrl;
    } tlviu_instr_t;

    // Peripheral request flags
    typedef struct packed {
        logic ext0_flag;
        logic ext0_edge_mode;
        logic ext1_flag;
        logic ext1_edge_mode;
        logic timer0_flag;
        logic timer1_flag;
        logic timer2_flag;
        logic timer2_external_flag;
        logic twowire_flag;
        logic uart1_recv_done_flag;
        logic uart1_xmit_done_flag;
        logic uart2_recv_done_flag;
        logic uart2_xmit_done_flag;
    } tlviu_flags_t;

    // Hardware-call order to the sequencer
    typedef struct packed {
        logic call;
        logic [15:0] vector;
        logic push_pc;
        logic save_status;
        logic pop_pc;
    } tlviu_call_t;
endpackage

//--- testbench/tlviu_flag_model.sv
// Partner model: peripheral request flags and the machine-cycle phase strobe
`timescale 1ns/1ns
module tlviu_flag_model
    import tlviu_pkg::*;
#(
    parameter int PHASE_DIV = 4
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    // Software set and clear of flags
    input wire tlviu_flags_t set_i,
    input wire tlviu_flags_t clr_i,
    // Hardware clears from the unit: ext0, ext1, timer0, timer1
    input wire logic [3:0] hw_clr_i,
    // Toward the unit
    output tlviu_flags_t flags_o,
    output logic phase_o
);
    logic [12:0] flags_reg;
    logic [12:0] hw_mask;
    logic [7:0] cnt_reg;

    // Serial and timer2 flags have no hardware clear, only software drops them
    assign hw_mask = {hw_clr_i[3], 1'b0, hw_clr_i[2], 1'b0, hw_clr_i[1:0], 7'h00};
    assign flags_o = flags_reg;

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_reg <= 13'h0000;
        end else begin
            flags_reg <= (flags_reg | set_i) & ~clr_i & ~hw_mask;
        end
    end

    // Short machine cycle keeps the run brief; the unit only needs one strobe per cycle
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= (cnt_reg == 8'(PHASE_DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
    assign phase_o = (cnt_reg == 8'h00) && arst_n_i;
endmodule // tlviu_flag_model

//--- testbench/tlviu_core_bench.sv
// Self-checking bench for the vectored interrupt unit
`timescale 1ns/1ns
module tlviu_core_bench;
    import tlviu_pkg::*;
    localparam int DIV = 4;
    localparam tlviu_instr_t LAST = 4'b1000;
    localparam tlviu_instr_t RETURN_FROM_HANDLER = 4'b1100;
    localparam tlviu_instr_t RET = 4'b1010;
    localparam tlviu_instr_t CTRL = 4'b1001;
    localparam tlviu_instr_t MID = 4'b0000;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic phase;
    tlviu_sfr_req_t sfr = '0;
    logic [7:0] rdata;
    tlviu_instr_t instr = '0;
    tlviu_flags_t flags;
    tlviu_flags_t fset = '0;
    tlviu_flags_t fclr = '0;
    tlviu_call_t call;
    logic [3:0] hw_clr;
    logic [1:0] in_prog;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    tlviu_core tlviu_core_inst (.core_clk_i(core_clk), .arst_n_i(arst_n), .flag_sample_phase_i(phase),
        .sfr_req_i(sfr), .sfr_rdata_o(rdata), .instr_i(instr), .flags_i(flags), .call_o(call),
        .ext0_clear_o(hw_clr[3]), .ext1_clear_o(hw_clr[2]), .timer0_clear_o(hw_clr[1]),
        .timer1_clear_o(hw_clr[0]), .in_progress_o(in_prog));
    tlviu_flag_model #(.PHASE_DIV(DIV)) tlviu_flag_model_inst (.core_clk_i(core_clk), .arst_n_i(arst_n),
        .set_i(fset), .clr_i(fclr), .hw_clr_i(hw_clr), .flags_o(flags), .phase_o(phase));

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge core_clk);
        sfr = '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge core_clk);
        sfr = '0;
        chk("rdata", {8'h00, e}, {8'h00, rdata});
    endtask

    task automatic flg(input logic [12:0] s, input logic [12:0] c);
        @(negedge core_clk);
        fset = s;
        fclr = c;
        @(negedge core_clk);
        fset = '0;
        fclr = '0;
    endtask

    // Lets the sampler take fresh flags, then runs one instruction cycle with the given status
    task automatic step(input tlviu_instr_t ins, input logic ec, input logic [15:0] ev, input logic [1:0] ep);
        repeat (2 * DIV) @(negedge core_clk);
        instr = ins;
        @(negedge core_clk);
        instr = '0;
        chk("call", {15'h0000, ec}, {15'h0000, call.call});
        chk("push", {15'h0000, ec}, {15'h0000, call.push_pc});
        chk("status save", 16'h0000, {15'h0000, call.save_status});
        if (ec) chk("vector", ev, call.vector);
        chk("pop", {15'h0000, ins.is_return_from_handler | ins.is_ret}, {15'h0000, call.pop_pc});
        chk("in progress", {14'h0000, ep}, {14'h0000, in_prog});
    endtask

    task automatic reg_test();
        logic [7:0] ad [4];
        logic [7:0] mk [4];
        ad = '{ADDR_ENABLE_AUX, ADDR_ENABLE_MAIN, ADDR_LEVEL_AUX, ADDR_LEVEL_MAIN};
        mk = '{8'h12, 8'hBF, 8'h12, 8'h3F};
        for (int i = 0; i < 4; i++) begin
            rd(ad[i], 8'h00);
            wr(ad[i], 8'hFF);
            rd(ad[i], mk[i]);
            wr(ad[i], 8'h00);
        end
        wr(8'hA9, 8'hFF);
        rd(8'hA9, 8'h00);
    endtask

    // One source at a time: ext0, uart2, timer0, two-wire, ext1, timer1, uart1, timer2
    task automatic vec_test();
        logic [12:0] fs [8];
        logic [7:0] em [8];
        logic [7:0] ea [8];
        logic [15:0] fv [8];
        logic [3:0] fh [8];
        fs = '{13'h1800, 13'h0001, 13'h0100, 13'h0010, 13'h0600, 13'h0080, 13'h0008, 13'h0020};
        em = '{8'h81, 8'h80, 8'h82, 8'h80, 8'h84, 8'h88, 8'h90, 8'hA0};
        ea = '{8'h00, 8'h10, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
        fv = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013, 16'h001B, 16'h0023, 16'h002B};
        fh = '{4'b1000, 4'b0000, 4'b0010, 4'b0000, 4'b0100, 4'b0001, 4'b0000, 4'b0000};
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_ENABLE_MAIN, em[i]);
            wr(ADDR_ENABLE_AUX, ea[i]);
            flg(fs[i], 13'h0000);
            step(LAST, 1'b1, fv[i], 2'b01);
            chk("clear pulses", {12'h000, fh[i]}, {12'h000, hw_clr});
            repeat (2) @(negedge core_clk);
            chk("flags kept", {3'h0, fs[i] & 13'h0A7F}, {3'h0, flags});
            step(RETURN_FROM_HANDLER, 1'b0, 16'h0000, 2'b00);
            flg(13'h0000, 13'h1FFF);
        end
    endtask

    task automatic prio_test();
        wr(ADDR_ENABLE_MAIN, 8'hBF);
        wr(ADDR_ENABLE_AUX, 8'h12);
        wr(ADDR_LEVEL_MAIN, 8'h20);
        flg(13'h10C0, 13'h0000);
        step(LAST, 1'b1, VEC_TIMER2, 2'b10);
        step(LAST, 1'b0, 16'h0000, 2'b10);
        flg(13'h0000, 13'h0040);
        step(RETURN_FROM_HANDLER, 1'b0, 16'h0000, 2'b00);
        step(LAST, 1'b1, VEC_EXT0, 2'b01);
        chk("clear pulses", 16'h0000, {12'h000, hw_clr});
        step(LAST, 1'b0, 16'h0000, 2'b01);
        flg(13'h0040, 13'h1000);
        step(LAST, 1'b1, VEC_TIMER2, 2'b11);
        flg(13'h0000, 13'h0040);
        step(RET, 1'b0, 16'h0000, 2'b11);
        step(LAST, 1'b0, 16'h0000, 2'b11);
        step(RETURN_FROM_HANDLER, 1'b0, 16'h0000, 2'b01);
        step(RETURN_FROM_HANDLER, 1'b0, 16'h0000, 2'b00);
        step(LAST, 1'b1, VEC_TIMER1, 2'b01);
        step(RETURN_FROM_HANDLER, 1'b0, 16'h0000, 2'b00);
        step(LAST, 1'b0, 16'h0000, 2'b00);
    endtask

    task automatic block_test();
        flg(13'h0100, 13'h0000);
        step(MID, 1'b0, 16'h0000, 2'b00);
        step(CTRL, 1'b0, 16'h0000, 2'b00);
        step(RETURN_FROM_HANDLER, 1'b0, 16'h0000, 2'b00);
        wr(ADDR_ENABLE_MAIN, 8'hBD);
        step(LAST, 1'b0, 16'h0000, 2'b00);
        wr(ADDR_ENABLE_MAIN, 8'h3F);
        step(LAST, 1'b0, 16'h0000, 2'b00);
        flg(13'h0000, 13'h0100);
        wr(ADDR_ENABLE_MAIN, 8'hBF);
        step(LAST, 1'b0, 16'h0000, 2'b00);
    endtask

    initial begin
        repeat (3) @(negedge core_clk);
        arst_n = 1'b1;
        reg_test();
        vec_test();
        prio_test();
        block_test();
        test_done();
    end
endmodule // tlviu_core_bench
